/* dv/pcm_cpu_model.sv */
/*
  far side model: cpu halt and interrupt pulses plus the reference clock.
  assumes requests from the bench arrive between rising edges.
*/
`timescale 1ns/1ns
module pcm_cpu_model (
  input wire mclk,
  input wire doHalt,
  input wire doWake,
  input wire [2:0] opMode,
  output reg haltExec = 1'b0,
  output reg wakeIrq = 1'b0,
  output reg extClk = 1'b1
);
  // pulses last one cycle; reference parked high while in standby
  always @(posedge mclk)
  begin
    haltExec <= doHalt;
    wakeIrq <= doWake;
    extClk <= (opMode == 3'h3) ? 1'b1 : ~extClk;
  end
endmodule // pcm_cpu_model

/* dv/pcm_ctrl_props.sv */
/*
  concurrent checks on the clock and power mode controller ports.
  assumes one clock domain and wait code 111 whenever standby is exercised.
*/
`timescale 1ns/1ns
module pcm_ctrl_props (
  input wire mclk,
  input wire sys_rst,
  input wire pll_mult_sel_lo,
  input wire pll_mult_sel_hi,
  input wire mult_switch_mode,
  input wire bus_clk_sel_2,
  input wire bus_clk_sel_1,
  input wire standby_wait_sel_0,
  input wire standby_wait_sel_1,
  input wire standby_wait_sel_2,
  input wire standby_on_halt,
  input wire haltExec,
  input wire [7:0] moduleStop,
  input wire [7:0] moduleResetOnStop,
  input wire [1:0] pllMult,
  input wire clkGenRun,
  input wire cpuClkEn,
  input wire periphClkEn,
  input wire [7:0] moduleSoftRst,
  input wire [2:0] opMode,
  input wire busSelError,
  input wire breakException,
  input wire busClkEn
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // joined fields, only for readability of the properties
  wire [1:0] multCode = {pll_mult_sel_hi, pll_mult_sel_lo};
  wire [2:0] waitCode = {standby_wait_sel_2, standby_wait_sel_1, standby_wait_sel_0};
  sequence s_wake;
    opMode == 3'h3 && waitCode == 3'h7 ##1 opMode == 3'h4;
  endsequence
  sequence s_code_held;
    ($stable(multCode) && mult_switch_mode && multCode != 2'h3) [*3];
  endsequence
  // reset must be visible even while it is asserted
  a_reset_state: assert property (disable iff (1'b0) sys_rst |=> pllMult == 2'h0 && opMode == 3'h0)
    else $error("state after reset wrong");
  a_halt_standby: assert property (opMode <= 3'h1 && haltExec && standby_on_halt |=> opMode == 3'h3)
    else $error("halt did not enter standby");
  a_halt_sleep: assert property (opMode <= 3'h1 && haltExec && !standby_on_halt |=> opMode == 3'h2)
    else $error("halt did not enter sleep");
  a_standby_gen_off: assert property (opMode == 3'h3 |-> !clkGenRun)
    else $error("clock generator running in standby");
  a_wait_cpu_off: assert property (opMode == 3'h4 |-> !cpuClkEn)
    else $error("cpu clock during stabilization wait");
  a_sleep_clocks: assert property (opMode == 3'h2 |-> periphClkEn && !cpuClkEn)
    else $error("sleep clock gating wrong");
  a_wait_length: assert property (s_wake |-> (opMode == 3'h4) [*8] ##1 (opMode == 3'h4) [*8] ##1 opMode <= 3'h1)
    else $error("stabilization wait length wrong");
  a_break_late: assert property (breakException |-> $past(opMode) == 3'h4 && opMode <= 3'h1)
    else $error("break taken outside wait end");
  a_bus_no_runt: assert property (opMode == 3'h1 && $past(opMode) == 3'h1 |-> !(busClkEn && $past(busClkEn)))
    else $error("bus clock pulse truncated");
  a_mult_now: assert property (s_code_held |-> pllMult == multCode)
    else $error("multiplier not applied at once");
  a_mod_reset: assert property (!$past(sys_rst) && $stable(moduleStop) && $stable(moduleResetOnStop)
    |-> moduleSoftRst == (moduleStop & moduleResetOnStop))
    else $error("module reset mask wrong");
  a_bus_code_bad: assert property ((bus_clk_sel_2 && bus_clk_sel_1) [*2] |-> busSelError)
    else $error("prohibited bus code not flagged");
endmodule // pcm_ctrl_props

bind pcm_ctrl pcm_ctrl_props u_props (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .pll_mult_sel_lo(pll_mult_sel_lo),
  .pll_mult_sel_hi(pll_mult_sel_hi),
  .mult_switch_mode(mult_switch_mode),
  .bus_clk_sel_2(bus_clk_sel_2),
  .bus_clk_sel_1(bus_clk_sel_1),
  .standby_wait_sel_0(standby_wait_sel_0),
  .standby_wait_sel_1(standby_wait_sel_1),
  .standby_wait_sel_2(standby_wait_sel_2),
  .standby_on_halt(standby_on_halt),
  .haltExec(haltExec),
  .moduleStop(moduleStop),
  .moduleResetOnStop(moduleResetOnStop),
  .pllMult(pllMult),
  .clkGenRun(clkGenRun),
  .cpuClkEn(cpuClkEn),
  .periphClkEn(periphClkEn),
  .moduleSoftRst(moduleSoftRst),
  .opMode(opMode),
  .busSelError(busSelError),
  .breakException(breakException),
  .busClkEn(busClkEn)
);

/* dv/pcm_ctrl_tb_top.sv */
/*
  self-checking bench for the clock and power mode controller.
  assumes the cpu model supplies halt, wake and the reference clock.
*/
`timescale 1ns/1ns
module pcm_ctrl_tb_top;
  reg mclk = 1'b0;
  reg sysRst = 1'b1;
  reg lo = 1'b0, hi = 1'b0, sw = 1'b0, soh = 1'b0, doHalt = 1'b0, doWake = 1'b0;
  reg brk = 1'b0;
  reg [2:0] bsel = 3'h0;
  reg [2:0] wsel = 3'h7;
  reg [7:0] mStop = 8'h00, mRst = 8'h00;
  wire haltExec, wakeIrq, extClk, clkGenRun, cpuClkEn, busClkEn, periphClkEn;
  wire multCodeError, busSelError;
  wire pllPhaseLock, breakException;
  wire [1:0] pllMult;
  wire [2:0] opMode;
  wire [7:0] moduleClkEn, moduleSoftRst;
  reg [7:0] n, m;
  integer failures = 0, checks = 0, cycles = 0;
  always #25 mclk = ~mclk;
  pcm_cpu_model u_cpu (.mclk(mclk), .doHalt(doHalt), .doWake(doWake), .opMode(opMode),
    .haltExec(haltExec), .wakeIrq(wakeIrq), .extClk(extClk));
  pcm_ctrl u_dut (.mclk(mclk), .sys_rst(sysRst), .ext_clock_in_pin(extClk),
    .pll_mult_sel_lo(lo), .pll_mult_sel_hi(hi), .mult_switch_mode(sw),
    .bus_clk_sel_2(bsel[2]), .bus_clk_sel_1(bsel[1]), .bus_clk_sel_0(bsel[0]),
    .standby_wait_sel_0(wsel[0]), .standby_wait_sel_1(wsel[1]), .standby_wait_sel_2(wsel[2]),
    .standby_on_halt(soh), .haltExec(haltExec), .pcBreakOnHalt(brk), .wakeIrq(wakeIrq),
    .moduleStop(mStop), .moduleResetOnStop(mRst), .pllMult(pllMult),
    .pllPhaseLock(pllPhaseLock),
    .clkGenRun(clkGenRun), .cpuClkEn(cpuClkEn), .busClkEn(busClkEn),
    .periphClkEn(periphClkEn), .moduleClkEn(moduleClkEn), .moduleSoftRst(moduleSoftRst),
    .breakException(breakException), .opMode(opMode), .multCodeError(multCodeError),
    .busSelError(busSelError));
  // hang guard, well above the roughly 1000 cycles the tests need
  always @(posedge mclk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      failures = failures + 1;
      print_verdict;
    end
  end
  task chk(input [7:0] seen, input [7:0] exp);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task tick(input integer c);
  begin
    repeat (c) @(negedge mclk);
  end
  endtask
  // bounded wait, so a stuck mode shows up as a mismatch
  task waitMode(input [2:0] exp);
    integer i;
  begin
    i = 0;
    while (opMode !== exp && i < 40)
    begin
      tick(1);
      i = i + 1;
    end
    chk(opMode, exp);
  end
  endtask
  task pulse(input integer w);
  begin
    if (w) doWake = 1'b1; else doHalt = 1'b1;
    tick(1);
    doWake = 1'b0;
    doHalt = 1'b0;
  end
  endtask
  task countBus;
  begin
    n = 8'h00;
    m = 8'h00;
    repeat (64)
    begin
      tick(1);
      n = n + busClkEn;
      m = m + pllPhaseLock;
    end
  end
  endtask
  task t_mult;
  begin
    sw = 1'b1;
    lo = 1'b1; tick(3); chk(pllMult, 8'h01);
    hi = 1'b1; tick(3); chk(multCodeError, 8'h01);
    chk(pllMult, 8'h01);
    lo = 1'b0; tick(3); chk(pllMult, 8'h02);
    lo = 1'b1; hi = 1'b0; tick(3); chk(pllMult, 8'h01);
  end
  endtask
  task t_standby;
  begin
    sw = 1'b0; lo = 1'b0; hi = 1'b1; tick(3);
    chk(pllMult, 8'h01);
    soh = 1'b1; pulse(0); waitMode(3'h3);
    tick(2); chk(clkGenRun, 8'h00);
    chk(pllMult, 8'h02);
    pulse(1); waitMode(3'h4);
    chk(cpuClkEn, 8'h00);
    // 16-state wait: still waiting on the 16th cycle, running on the 17th
    tick(15);
    chk(opMode, 8'h04);
    tick(1);
    chk(opMode, 8'h00);
    chk(cpuClkEn, 8'h01);
    waitMode(3'h0);
    chk(pllMult, 8'h02);
  end
  endtask
  task t_sleep;
  begin
    soh = 1'b0; pulse(0); waitMode(3'h2);
    chk(periphClkEn, 8'h01);
    chk(cpuClkEn, 8'h00);
    pulse(1); waitMode(3'h0);
  end
  endtask
  task t_modstop;
  begin
    mStop = 8'h0f; mRst = 8'h05; tick(3);
    chk(moduleClkEn, 8'hf0);
    chk(moduleSoftRst, 8'h05);
  end
  endtask
  task t_bus;
    integer k;
  begin
    // each legal divider code halves the pulses seen in 64 cycles
    for (k = 1; k <= 5; k = k + 1)
    begin
      bsel = k[2:0];
      tick(40);
      countBus;
      chk(n, 8'h40 >> k);
    end
    bsel = 3'h2; tick(40); countBus; chk(n, 8'h10);
    chk(m, 8'h20);
    chk(opMode, 8'h01);
    chk(moduleClkEn, 8'hf0);
    bsel = 3'h6; tick(40); chk(busSelError, 8'h01);
    countBus; chk(n, 8'h10);
    bsel = 3'h0; tick(40); countBus; chk(n, 8'h40);
  end
  endtask
  // break armed on halt: standby entered, left with no interrupt after the wait
  task t_break;
  begin
    soh = 1'b1;
    brk = 1'b1;
    pulse(0);
    waitMode(3'h3);
    brk = 1'b0;
    waitMode(3'h4);
    chk(breakException, 8'h00);
    waitMode(3'h0);
    chk(breakException, 8'h01);
    tick(1);
    chk(breakException, 8'h00);
  end
  endtask
  task print_verdict;
  begin
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  initial
  begin
    tick(10);
    sysRst = 1'b0;
    tick(1);
    chk(pllMult, 8'h00);
    chk(opMode, 8'h00);
    t_mult;
    t_standby;
    t_sleep;
    t_modstop;
    t_bus;
    t_break;
    print_verdict;
  end
endmodule // pcm_ctrl_tb_top

/* rtl/pcm_consts.vh */
/*
  constants for the clock and power mode controller: multiplier codes,
  bus clock codes, standby wait counts and operating mode codes.
  assumes nothing beyond being included by the controller files.
*/
`ifndef PCM_CONSTS_VH
`define PCM_CONSTS_VH

// pll multiplier select codes
`define PCM_MULT_X1 2'h0
`define PCM_MULT_X2 2'h1
`define PCM_MULT_X4 2'h2
`define PCM_MULT_BAD 2'h3

// bus clock select codes
`define PCM_BCK_FULL 3'h0
`define PCM_BCK_DIV2 3'h1
`define PCM_BCK_DIV32 3'h5

// standby wait lengths in states
`define PCM_WAIT_8K 19'h02000
`define PCM_WAIT_16K 19'h04000
`define PCM_WAIT_32K 19'h08000
`define PCM_WAIT_64K 19'h10000
`define PCM_WAIT_128K 19'h20000
`define PCM_WAIT_256K 19'h40000
`define PCM_WAIT_16 19'h00010
`define PCM_WAIT_CODE_RSVD 3'h6
`define PCM_WAIT_CODE_16 3'h7

// operating mode codes
`define PCM_MODE_HIGH 3'h0
`define PCM_MODE_MED 3'h1
`define PCM_MODE_SLEEP 3'h2
`define PCM_MODE_STANDBY_ON_HALT 3'h3
`define PCM_MODE_WAIT 3'h4

// reset values and module count
`define PCM_MULT_RESET 2'h0
`define PCM_NUM_MODULES 8

`endif

/* rtl/pcm_ctrl.v */
/*
  clock and power mode controller: pll multiplier control, medium-speed
  bus clock enables, halt/sleep/software standby sequencing and module stop.
  assumes halt and wake requests come from same-clock cpu logic, and that
  the analog pll follows pllMult; clocks are delivered as enables on mclk.
*/
`timescale 1ns/1ns
`include "pcm_consts.vh"
module pcm_ctrl (
  input wire mclk,
  input wire sys_rst,
  input wire ext_clock_in_pin,
  input wire pll_mult_sel_lo,
  input wire pll_mult_sel_hi,
  input wire mult_switch_mode,
  input wire bus_clk_sel_2,
  input wire bus_clk_sel_1,
  input wire bus_clk_sel_0,
  input wire standby_wait_sel_0,
  input wire standby_wait_sel_1,
  input wire standby_wait_sel_2,
  input wire standby_on_halt,
  input wire haltExec,
  input wire pcBreakOnHalt,
  input wire wakeIrq,
  input wire [7:0] moduleStop,
  input wire [7:0] moduleResetOnStop,
  output reg [1:0] pllMult,
  output reg pllPhaseLock,
  output reg clkGenRun,
  output reg cpuClkEn,
  output reg busClkEn,
  output reg periphClkEn,
  output reg [7:0] moduleClkEn,
  output reg [7:0] moduleSoftRst,
  output reg breakException,
  output reg [2:0] opMode,
  output reg multCodeError,
  output reg busSelError
);
  wire [1:0] multSel;
  wire [2:0] busSel;
  wire [2:0] waitSel;
  wire [4:0] divCount;
  wire [4:0] divWrap;
  wire waitDone;
  wire [18:0] waitRemain;
  reg [18:0] waitLen;
  reg [1:0] pendMult;
  reg [2:0] activeSel;
  reg [2:0] state;
  reg [2:0] next_state;
  reg breakPend;
  reg extSync1;
  reg extSync2;
  reg extPrev;
  reg next_busEn;
  reg waitLoad;
  wire periphOn;

  localparam ST_RUN = 3'h0;
  localparam ST_SLEEP = 3'h1;
  localparam ST_STOP = 3'h2;
  localparam ST_WAIT = 3'h3;

  assign multSel = {pll_mult_sel_hi, pll_mult_sel_lo};
  assign busSel = {bus_clk_sel_2, bus_clk_sel_1, bus_clk_sel_0};
  assign waitSel = {standby_wait_sel_2, standby_wait_sel_1, standby_wait_sel_0};
  // peripherals stay clocked in run and sleep, stopped through standby and wait
  assign periphOn = (next_state == ST_RUN) || (next_state == ST_SLEEP);

  pcm_divider uDiv (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .divCount(divCount),
    .divWrap(divWrap)
  );

  pcm_wait_timer uWait (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .load(waitLoad),
    .length(waitLen),
    .done(waitDone),
    .remain(waitRemain)
  );

  // wait length lookup; reserved code falls back to the longest wait for safety
  always @*
  begin
    case (waitSel)
      3'h0: waitLen = `PCM_WAIT_8K;
      3'h1: waitLen = `PCM_WAIT_16K;
      3'h2: waitLen = `PCM_WAIT_32K;
      3'h3: waitLen = `PCM_WAIT_64K;
      3'h4: waitLen = `PCM_WAIT_128K;
      3'h5: waitLen = `PCM_WAIT_256K;
      `PCM_WAIT_CODE_16: waitLen = `PCM_WAIT_16;
      default: waitLen = `PCM_WAIT_256K;
    endcase
  end

  // mode sequencing: halt picks sleep or standby, interrupt wakes
  always @*
  begin
    next_state = state;
    waitLoad = 1'b0;
    case (state)
      ST_RUN:
      begin
        if (haltExec)
          next_state = standby_on_halt ? ST_STOP : ST_SLEEP;
      end
      ST_SLEEP:
      begin
        if (wakeIrq)
          next_state = ST_RUN;
      end
      ST_STOP:
      begin
        if (wakeIrq | breakPend)
        begin
          next_state = ST_WAIT;
          waitLoad = 1'b1;
        end
      end
      ST_WAIT:
      begin
        if (waitDone)
          next_state = ST_RUN;
      end
      default: next_state = ST_RUN;
    endcase
  end

  // state register; reset lands in running high-speed state
  always @(posedge mclk)
  begin
    if (sys_rst)
      state <= ST_RUN;
    else
      state <= next_state;
  end

  // multiplier: deferred until standby entry, or immediate in switch mode 1
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pllMult <= `PCM_MULT_RESET;
      pendMult <= `PCM_MULT_RESET;
      multCodeError <= 1'b0;
    end
    else
    begin
      multCodeError <= (multSel == `PCM_MULT_BAD);
      // prohibited code is never latched; last legal factor is kept
      if (multSel != `PCM_MULT_BAD)
        pendMult <= multSel;
      if (mult_switch_mode && multSel != `PCM_MULT_BAD)
        pllMult <= multSel;
      else if (state == ST_STOP && !mult_switch_mode)
        pllMult <= pendMult;
    end
  end

  // break on halt: standby still entered, break raised after the wait
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      breakPend <= 1'b0;
      breakException <= 1'b0;
    end
    else
    begin
      breakException <= 1'b0;
      if (state == ST_RUN && haltExec && standby_on_halt && pcBreakOnHalt)
        breakPend <= 1'b1;
      else if (state == ST_WAIT && waitDone && breakPend)
      begin
        breakPend <= 1'b0;
        breakException <= 1'b1;
      end
    end
  end

  // external clock sampled twice before edge detect for phase tracking
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      // parked high like the pin in standby, so release shows no false edge
      extSync1 <= 1'b1;
      extSync2 <= 1'b1;
      extPrev <= 1'b1;
      pllPhaseLock <= 1'b0;
    end
    else
    begin
      extSync1 <= ext_clock_in_pin;
      extSync2 <= extSync1;
      extPrev <= extSync2;
      // marks the cycle aligned to the reference rising edge
      pllPhaseLock <= extSync2 & ~extPrev;
    end
  end

  // bus clock select only changes at the slowest divider wrap, so no short pulse
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      activeSel <= `PCM_BCK_FULL;
      busSelError <= 1'b0;
    end
    else
    begin
      busSelError <= (busSel > `PCM_BCK_DIV32);
      if (divWrap[4] && busSel <= `PCM_BCK_DIV32)
        activeSel <= busSel;
    end
  end

  // enable for the selected divided clock
  always @*
  begin
    if (activeSel == `PCM_BCK_FULL)
      next_busEn = 1'b1;
    else if (activeSel <= `PCM_BCK_DIV32)
      next_busEn = divWrap[activeSel - `PCM_BCK_DIV2];
    else
      next_busEn = 1'b1;
  end

  // clock gating outputs per mode; sleep keeps generator and peripherals going
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      clkGenRun <= 1'b1;
      cpuClkEn <= 1'b1;
      busClkEn <= 1'b1;
      periphClkEn <= 1'b1;
      opMode <= `PCM_MODE_HIGH;
    end
    else
    begin
      clkGenRun <= (next_state != ST_STOP);
      periphClkEn <= (next_state == ST_RUN) || (next_state == ST_SLEEP);
      // medium speed gates only cpu and bus masters
      cpuClkEn <= (next_state == ST_RUN) && next_busEn;
      busClkEn <= (next_state == ST_RUN) && next_busEn;
      case (next_state)
        ST_RUN: opMode <= (activeSel == `PCM_BCK_FULL) ? `PCM_MODE_HIGH : `PCM_MODE_MED;
        ST_SLEEP: opMode <= `PCM_MODE_SLEEP;
        ST_STOP: opMode <= `PCM_MODE_STANDBY_ON_HALT;
        ST_WAIT: opMode <= `PCM_MODE_WAIT;
        default: opMode <= `PCM_MODE_HIGH;
      endcase
    end
  end

  // module stop: only flagged modules halt in run and sleep, all halt in standby and wait; reset-type ones get initialized
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      moduleClkEn <= 8'hff;
      moduleSoftRst <= 8'h00;
    end
    else
    begin
      moduleClkEn <= periphOn ? ~moduleStop : 8'h00;
      moduleSoftRst <= moduleStop & moduleResetOnStop;
    end
  end
endmodule // pcm_ctrl

/* rtl/pcm_divider.v */
/*
  medium-speed divider: free-running counter giving sys/2 .. sys/32 enables.
  assumes it runs on the system clock and is cleared by the block reset.
*/
`timescale 1ns/1ns
module pcm_divider (
  input wire mclk,
  input wire sys_rst,
  output reg [4:0] divCount,
  output wire [4:0] divWrap
);
  genvar i;

  // counter bit i toggling at its wrap gives divide by 2^(i+1)
  always @(posedge mclk)
  begin
    if (sys_rst)
      divCount <= 5'h00;
    else
      divCount <= divCount + 5'h01;
  end

  // wrap of each divider: all low bits set, so each tick is one full period
  generate
    for (i = 0; i < 5; i = i + 1)
    begin : gWrap
      assign divWrap[i] = &divCount[i:0];
    end
  endgenerate
endmodule // pcm_divider

/* rtl/pcm_wait_timer.v */
/*
  standby stabilization wait counter: loads a length, counts down, flags done.
  assumes length is stable while load is high and the clock runs during the wait.
*/
`timescale 1ns/1ns
module pcm_wait_timer (
  input wire mclk,
  input wire sys_rst,
  input wire load,
  input wire [18:0] length,
  output wire done,
  output reg [18:0] remain
);
  // down counter loaded with length less one; the first wait state is the cycle
  // after the load cycle, so done while zero gives exactly n cycles for n states
  always @(posedge mclk)
  begin
    if (sys_rst)
      remain <= 19'h00000;
    else if (load)
      remain <= length - 19'h00001;
    else if (remain != 19'h00000)
      remain <= remain - 19'h00001;
  end

  assign done = (remain == 19'h00000) & ~load;
endmodule // pcm_wait_timer
